// [hdl/pwm_register_write_lock.sv]
// Guarded output-control and fault/current-limit registers of the PWM generators
// Assumes a single-cycle register port; config word sampled as a level
`timescale 1ns/1ps
`default_nettype none
module pwm_register_write_lock
  import pwm_lock_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic [15:0]       oscillatorSelectConfigWord,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic [DATA_W-1:0]      rdata,
  output logic [DATA_W*NUM_GEN-1:0] generatorOutputControl,
  output logic [DATA_W*NUM_GEN-1:0] faultCurrentLimitControl
);
  // ----------------------------------------------------------------
  // Guard enable and sequence tracking
  // ----------------------------------------------------------------
  logic         writeGuardConfigBit;
  logic         unlocked;
  logic         keyWrite;
  logic         anyAccess;
  logic         protHit;
  logic         writeAllowed;
  guard_state_t guardState;

  assign writeGuardConfigBit = oscillatorSelectConfigWord[WRITE_GUARD_BIT_POS];
  assign keyWrite = wr && addr == UNLOCK_KEY_REGISTER_ADDR;
  assign anyAccess = wr || rd;
  assign writeAllowed = !writeGuardConfigBit || unlocked;

  write_guard_fsm i_write_guard_fsm (
    .clk        (clk),
    .arst_n     (arst_n),
    .anyAccess  (anyAccess),
    .keyWrite   (keyWrite),
    .keyData    (wdata),
    .unlocked   (unlocked),
    .guardState (guardState)
  );

  // ----------------------------------------------------------------
  // Protected registers, one pair per generator
  // ----------------------------------------------------------------
  logic [NUM_GEN-1:0] ocHit;
  logic [NUM_GEN-1:0] fcHit;

  genvar g;
  generate
    for (g = 0; g < NUM_GEN; g++) begin : gen_reg
      assign ocHit[g] = wr && addr == GEN_OUTPUT_CONTROL_BASE + ADDR_W'(g);
      assign fcHit[g] = wr && addr == FAULT_CURRENT_LIMIT_BASE + ADDR_W'(g);
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          generatorOutputControl[g*DATA_W +: DATA_W] <= CONTROL_RESET;
          faultCurrentLimitControl[g*DATA_W +: DATA_W] <= CONTROL_RESET;
        end else begin
          if (ocHit[g] && writeAllowed) generatorOutputControl[g*DATA_W +: DATA_W] <= wdata;
          if (fcHit[g] && writeAllowed) faultCurrentLimitControl[g*DATA_W +: DATA_W] <= wdata;
        end
      end
    end
  endgenerate

  assign protHit = |{ocHit, fcHit};

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] next_rdata;
  always_comb begin
    next_rdata = '0;
    if (addr == STATUS_ADDR) next_rdata = {13'h0000, writeGuardConfigBit, 2'(guardState)};
    for (int i = 0; i < NUM_GEN; i++) begin
      if (addr == GEN_OUTPUT_CONTROL_BASE + ADDR_W'(i))
        next_rdata = generatorOutputControl[i*DATA_W +: DATA_W];
      if (addr == FAULT_CURRENT_LIMIT_BASE + ADDR_W'(i))
        next_rdata = faultCurrentLimitControl[i*DATA_W +: DATA_W];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) rdata <= '0;
    else if (rd) rdata <= next_rdata;
    else rdata <= '0;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_locked_write_blocked: assert property (@(posedge clk) disable iff (!arst_n)
    ocHit[0] && writeGuardConfigBit && !unlocked |=> $stable(generatorOutputControl[DATA_W-1:0]))
    else $error("Locked write changed output control");
  chk_fault_write_blocked: assert property (@(posedge clk) disable iff (!arst_n)
    fcHit[0] && writeGuardConfigBit && !unlocked |=> $stable(faultCurrentLimitControl[DATA_W-1:0]))
    else $error("Locked write changed fault control");
  chk_guard_off_free: assert property (@(posedge clk) disable iff (!arst_n)
    ocHit[0] && !writeGuardConfigBit |=> generatorOutputControl[DATA_W-1:0] == $past(wdata))
    else $error("Unguarded write not taken");
  chk_unlocked_write_taken: assert property (@(posedge clk) disable iff (!arst_n)
    fcHit[0] && unlocked |=> faultCurrentLimitControl[DATA_W-1:0] == $past(wdata))
    else $error("Unlocked write not taken");
  chk_second_write_blocked: assert property (@(posedge clk) disable iff (!arst_n)
    protHit && unlocked && writeGuardConfigBit ##1 ocHit[0] |=> $stable(generatorOutputControl[DATA_W-1:0]))
    else $error("Second write after one unlock taken");
  chk_stray_access_rearms: assert property (@(posedge clk) disable iff (!arst_n)
    unlocked && rd |=> !unlocked)
    else $error("Read did not consume unlock");
  chk_read_data_once: assert property (@(posedge clk) disable iff (!arst_n)
    !rd |=> rdata == '0)
    else $error("Read data held past its cycle");

  // ----------------------------------------------------------------
  // Sequence checks
  // ----------------------------------------------------------------
  chk_first_key_steps: assert property (@(posedge clk) disable iff (!arst_n)
    guardState == ARMED && keyWrite && wdata == KEY_FIRST |=> guardState == GOT_FIRST)
    else $error("First key not taken");
  chk_second_key_unlocks: assert property (@(posedge clk) disable iff (!arst_n)
    guardState == GOT_FIRST && keyWrite && wdata == KEY_SECOND |=> guardState == UNLOCKED)
    else $error("Second key did not unlock");
  chk_armed_stays_armed: assert property (@(posedge clk) disable iff (!arst_n)
    guardState == ARMED && !(keyWrite && wdata == KEY_FIRST) |=> guardState == ARMED)
    else $error("Armed state left without first key");
  chk_unlock_after_first: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(unlocked) |-> $past(guardState) == GOT_FIRST)
    else $error("Unlock skipped the first key");
  chk_access_ends_unlock: assert property (@(posedge clk) disable iff (!arst_n)
    unlocked && anyAccess |=> guardState == ARMED)
    else $error("Unlock outlived the next access");
  chk_key_write_consumes: assert property (@(posedge clk) disable iff (!arst_n)
    unlocked && keyWrite |=> guardState == ARMED)
    else $error("Key write kept the unlock");

  chk_stray_write_rearms: assert property (@(posedge clk) disable iff (!arst_n)
    guardState == GOT_FIRST && wr && !keyWrite |=> guardState == ARMED)
    else $error("Stray write kept the partial unlock");
  chk_stray_read_rearms: assert property (@(posedge clk) disable iff (!arst_n)
    guardState == GOT_FIRST && rd |=> guardState == ARMED)
    else $error("Stray read kept the partial unlock");
  chk_idle_holds_state: assert property (@(posedge clk) disable iff (!arst_n)
    !anyAccess |=> $stable(guardState))
    else $error("Sequence state moved without an access");

  // ----------------------------------------------------------------
  // Read path checks
  // ----------------------------------------------------------------
  chk_status_read_value: assert property (@(posedge clk) disable iff (!arst_n)
    rd && addr == STATUS_ADDR |=> rdata == {13'h0000, $past(writeGuardConfigBit), 2'($past(guardState))})
    else $error("Status read value wrong");
  chk_key_read_zero: assert property (@(posedge clk) disable iff (!arst_n)
    rd && addr == UNLOCK_KEY_REGISTER_ADDR |=> rdata == '0)
    else $error("Key register read not zero");

  // ----------------------------------------------------------------
  // Per-generator checks
  // ----------------------------------------------------------------
  generate
    for (g = 0; g < NUM_GEN; g++) begin : gen_chk
      chk_oc_locked_hold: assert property (@(posedge clk) disable iff (!arst_n)
        ocHit[g] && writeGuardConfigBit && guardState != UNLOCKED |=>
          $stable(generatorOutputControl[g*DATA_W +: DATA_W]))
        else $error("Locked output control write taken");
      chk_fc_locked_hold: assert property (@(posedge clk) disable iff (!arst_n)
        fcHit[g] && writeGuardConfigBit && guardState != UNLOCKED |=>
          $stable(faultCurrentLimitControl[g*DATA_W +: DATA_W]))
        else $error("Locked fault control write taken");

      chk_oc_free_write: assert property (@(posedge clk) disable iff (!arst_n)
        ocHit[g] && !writeGuardConfigBit |=> generatorOutputControl[g*DATA_W +: DATA_W] == $past(wdata))
        else $error("Free output control write lost");
      chk_fc_free_write: assert property (@(posedge clk) disable iff (!arst_n)
        fcHit[g] && !writeGuardConfigBit |=> faultCurrentLimitControl[g*DATA_W +: DATA_W] == $past(wdata))
        else $error("Free fault control write lost");
      chk_oc_unlock_write: assert property (@(posedge clk) disable iff (!arst_n)
        ocHit[g] && guardState == UNLOCKED |=> generatorOutputControl[g*DATA_W +: DATA_W] == $past(wdata))
        else $error("Unlocked output control write lost");
      chk_fc_unlock_write: assert property (@(posedge clk) disable iff (!arst_n)
        fcHit[g] && guardState == UNLOCKED |=> faultCurrentLimitControl[g*DATA_W +: DATA_W] == $past(wdata))
        else $error("Unlocked fault control write lost");

      chk_oc_no_stray: assert property (@(posedge clk) disable iff (!arst_n)
        !ocHit[g] |=> $stable(generatorOutputControl[g*DATA_W +: DATA_W]))
        else $error("Output control changed without a write");
      chk_fc_no_stray: assert property (@(posedge clk) disable iff (!arst_n)
        !fcHit[g] |=> $stable(faultCurrentLimitControl[g*DATA_W +: DATA_W]))
        else $error("Fault control changed without a write");
      chk_oc_read_back: assert property (@(posedge clk) disable iff (!arst_n)
        rd && addr == GEN_OUTPUT_CONTROL_BASE + ADDR_W'(g) |=>
          rdata == $past(generatorOutputControl[g*DATA_W +: DATA_W]))
        else $error("Output control read back wrong");
      chk_fc_read_back: assert property (@(posedge clk) disable iff (!arst_n)
        rd && addr == FAULT_CURRENT_LIMIT_BASE + ADDR_W'(g) |=>
          rdata == $past(faultCurrentLimitControl[g*DATA_W +: DATA_W]))
        else $error("Fault control read back wrong");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------
  cov_unlock_then_write: cover property (@(posedge clk) disable iff (!arst_n) unlocked && protHit);
  cov_wrong_second_key: cover property (@(posedge clk) disable iff (!arst_n)
    guardState == GOT_FIRST && keyWrite && wdata != KEY_SECOND);
  cov_guard_disabled: cover property (@(posedge clk) disable iff (!arst_n) protHit && !writeGuardConfigBit);
  cov_read_breaks_unlock: cover property (@(posedge clk) disable iff (!arst_n)
    unlocked && rd);
  cov_stray_after_first: cover property (@(posedge clk) disable iff (!arst_n)
    guardState == GOT_FIRST && rd);
endmodule : pwm_register_write_lock
`default_nettype wire

// [hdl/pwm_lock_pkg.sv]
// Constants for the guarded write path of the PWM control registers
// Assumes a 16-bit register port and a 20 MHz system clock
package pwm_lock_pkg;
  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam int          ADDR_W = 8;
  localparam int          DATA_W = 16;
  localparam int          NUM_GEN = 3;
  // Map of the register port
  localparam logic [7:0] UNLOCK_KEY_REGISTER_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h01;
  localparam logic [7:0] GEN_OUTPUT_CONTROL_BASE = 8'h10;
  localparam logic [7:0] FAULT_CURRENT_LIMIT_BASE = 8'h20;
  // ----------------------------------------------------------------
  // Keys and config word layout
  // ----------------------------------------------------------------
  localparam logic [15:0] KEY_FIRST = 16'habcd;
  localparam logic [15:0] KEY_SECOND = 16'h4321;
  localparam int          WRITE_GUARD_BIT_POS = 6;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] OSC_SELECT_DEFAULT = 16'h0040;

  typedef enum logic [1:0] {ARMED, GOT_FIRST, UNLOCKED} guard_state_t;
endpackage : pwm_lock_pkg

// [hdl/write_guard_fsm.sv]
// Key-sequence tracker granting one protected write per unlock
// Assumes one register access per cycle at most
`timescale 1ns/1ps
`default_nettype none
module write_guard_fsm
  import pwm_lock_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              anyAccess,
  input  wire logic              keyWrite,
  input  wire logic [DATA_W-1:0] keyData,
  output logic                   unlocked,
  output guard_state_t           guardState
);
  guard_state_t next_state;

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb begin
    next_state = guardState;
    case (guardState)
      ARMED: begin
        if (keyWrite && keyData == KEY_FIRST) next_state = GOT_FIRST;
      end
      GOT_FIRST: begin
        if (keyWrite && keyData == KEY_SECOND) next_state = UNLOCKED;
        else if (anyAccess) next_state = ARMED;
      end
      UNLOCKED: begin
        if (anyAccess) next_state = ARMED;
      end
      default: next_state = ARMED;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) guardState <= ARMED;
    else guardState <= next_state;
  end

  assign unlocked = (guardState == UNLOCKED);

  chk_unlock_needs_pair: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(unlocked) |-> $past(keyWrite) && $past(keyData) == KEY_SECOND)
    else $error("Unlock without second key");
  chk_unlock_single_use: assert property (@(posedge clk) disable iff (!arst_n)
    unlocked && anyAccess |=> !unlocked)
    else $error("Unlock survived an access");
  chk_wrong_key_rearms: assert property (@(posedge clk) disable iff (!arst_n)
    guardState == GOT_FIRST && anyAccess && !(keyWrite && keyData == KEY_SECOND) |=> guardState == ARMED)
    else $error("Broken sequence did not rearm");
endmodule : write_guard_fsm
`default_nettype wire

// [tb/tb_pwm_register_write_lock.sv]
// Self-checking bench for the guarded PWM control registers
// Assumes the register port map and keys of pwm_lock_pkg
`timescale 1ns/1ps
`default_nettype none
module tb_pwm_register_write_lock
  import pwm_lock_pkg::*;
;
  logic                      clk;
  logic                      arst_n;
  logic                      wr;
  logic                      rd;
  logic [15:0]               cfg;
  logic [DATA_W-1:0]         wdata;
  logic [DATA_W-1:0]         rdata;
  logic [ADDR_W-1:0]         addr;
  logic [DATA_W*NUM_GEN-1:0] outCtl;
  logic [DATA_W*NUM_GEN-1:0] fltCtl;
  int                        miscompares = 0;
  int                        total_checks = 0;

  pwm_register_write_lock i_pwm_register_write_lock (
    .clk(clk), .arst_n(arst_n), .oscillatorSelectConfigWord(cfg), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .generatorOutputControl(outCtl), .faultCurrentLimitControl(fltCtl));

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd_chk
  task automatic unlock(input logic [15:0] k1, input logic [15:0] k2);
    wr_reg(UNLOCK_KEY_REGISTER_ADDR, k1);
    wr_reg(UNLOCK_KEY_REGISTER_ADDR, k2);
  endtask : unlock

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_armed;
    chk(outCtl[15:0], CONTROL_RESET);
    rd_chk(STATUS_ADDR, 16'h0004);
    wr_reg(GEN_OUTPUT_CONTROL_BASE, 16'h1234);
    chk(outCtl[15:0], CONTROL_RESET);
    rd_chk(8'h7f, 16'h0000);
    $display("test armed done");
  endtask : t_armed
  task automatic t_unlock;
    unlock(KEY_FIRST, KEY_SECOND);
    wr_reg(GEN_OUTPUT_CONTROL_BASE + 8'h01, 16'hf000);
    chk(outCtl[31:16], 16'hf000);
    wr_reg(FAULT_CURRENT_LIMIT_BASE + 8'h01, 16'h5a5a);
    chk(fltCtl[31:16], CONTROL_RESET);
    unlock(KEY_FIRST, KEY_SECOND);
    wr_reg(FAULT_CURRENT_LIMIT_BASE + 8'h01, 16'h5a5a);
    chk(fltCtl[31:16], 16'h5a5a);
    rd_chk(FAULT_CURRENT_LIMIT_BASE + 8'h01, 16'h5a5a);
    unlock(KEY_FIRST, KEY_SECOND);
    rd_chk(STATUS_ADDR, 16'h0006);
    wr_reg(GEN_OUTPUT_CONTROL_BASE + 8'h02, 16'h0f0f);
    chk(outCtl[47:32], CONTROL_RESET);
    $display("test unlock done");
  endtask : t_unlock
  task automatic t_broken;
    unlock(KEY_FIRST, 16'h4320);
    wr_reg(FAULT_CURRENT_LIMIT_BASE, 16'h00ff);
    chk(fltCtl[15:0], CONTROL_RESET);
    unlock(KEY_SECOND, KEY_FIRST);
    wr_reg(FAULT_CURRENT_LIMIT_BASE, 16'h00ff);
    chk(fltCtl[15:0], CONTROL_RESET);
    wr_reg(UNLOCK_KEY_REGISTER_ADDR, KEY_FIRST);
    rd_chk(STATUS_ADDR, 16'h0005);
    wr_reg(UNLOCK_KEY_REGISTER_ADDR, KEY_SECOND);
    wr_reg(FAULT_CURRENT_LIMIT_BASE, 16'h00ff);
    chk(fltCtl[15:0], CONTROL_RESET);
    $display("test broken done");
  endtask : t_broken
  task automatic t_free;
    @(posedge clk);
    cfg <= 16'hffbf;
    wr_reg(GEN_OUTPUT_CONTROL_BASE + 8'h02, 16'h1111);
    chk(outCtl[47:32], 16'h1111);
    rd_chk(GEN_OUTPUT_CONTROL_BASE + 8'h02, 16'h1111);
    rd_chk(STATUS_ADDR, 16'h0000);
    @(posedge clk);
    cfg <= 16'h0040;
    wr_reg(GEN_OUTPUT_CONTROL_BASE + 8'h02, 16'h2222);
    chk(outCtl[47:32], 16'h1111);
    $display("test free done");
  endtask : t_free

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    {arst_n, wr, rd, addr, wdata} = '0;
    cfg = OSC_SELECT_DEFAULT;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    t_armed();
    t_unlock();
    t_broken();
    t_free();
    summarize();
  end
endmodule : tb_pwm_register_write_lock
`default_nettype wire
